/* src/rxfifo_dev.sv */
// Receive slice FIFO: eight entries, filled by deserialized words, drained
// by the user side through the link interface.
// Assumes the deserializer presents one word per write strobe on clk_in.
//
`timescale 1ns/100ps
module rxfifo_dev (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic width8_sel_in,
  input wire logic sync_bypass_in,
  input wire logic serial_in,
  input wire logic wr_strobe_in,
  input wire rxfifo_pkg::rxfifo_word_t wr_data_in,
  output logic overrun_out,
  output rxfifo_pkg::rxfifo_ptr_t level_out,
  rxfifo_link_if.dev link
);

  ////////////////////////////////////////////////////////////////////////
  // Storage and pointers

  // Pointers wrap freely, three bits span all entries
  rxfifo_pkg::rxfifo_word_t mem_q [rxfifo_pkg::RXFIFO_DEPTH];
  rxfifo_pkg::rxfifo_ptr_t wr_ptr_q;
  rxfifo_pkg::rxfifo_ptr_t wr_ptr_d;
  rxfifo_pkg::rxfifo_ptr_t rd_ptr_q;
  rxfifo_pkg::rxfifo_ptr_t rd_ptr_d;
  rxfifo_pkg::rxfifo_word_t wr_word;
  rxfifo_pkg::rxfifo_word_t q_q;
  logic echo_q;
  logic fill_clk_q;
  logic overrun_q;
  rxfifo_pkg::rxfifo_ptr_t level_q;
  logic empty_raw;
  logic empty_sync;
  logic empty_now;
  logic rd_room;
  logic rd_go;

  ////////////////////////////////////////////////////////////////////////
  // Width handling
  // Narrow words store zero in the upper nibble

  always_comb begin
    if (width8_sel_in) begin
      wr_word = wr_data_in;
    end else begin
      wr_word = wr_data_in & rxfifo_pkg::RXFIFO_NARROW_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write side

  always_comb begin
    if (wr_strobe_in) begin
      wr_ptr_d = wr_ptr_q + rxfifo_pkg::RXFIFO_PTR_ONE;
    end else begin
      wr_ptr_d = wr_ptr_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr_q <= rxfifo_pkg::RXFIFO_PTR_RST;
    end else begin
      wr_ptr_q <= wr_ptr_d;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < rxfifo_pkg::RXFIFO_DEPTH; gi++) begin : g_entry
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          mem_q[gi] <= rxfifo_pkg::RXFIFO_DATA_RST;
        end else if (wr_strobe_in && (wr_ptr_q == rxfifo_pkg::rxfifo_ptr_t'(gi))) begin
          mem_q[gi] <= wr_word;
        end
      end
    end
  endgenerate

  // Write clock copy toggles once per written word
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fill_clk_q <= 1'b0;
    end else if (wr_strobe_in) begin
      fill_clk_q <= ~fill_clk_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Empty detection and crossing

  // Sync stages reset to empty, so no stale word shows after reset
  assign empty_raw = (wr_ptr_q == rd_ptr_q);

  rxfifo_sync u_empty_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .level_in(empty_raw),
    .level_out(empty_sync)
  );

  // Bypass drops the crossing delay when both sides are synchronous
  assign empty_now = sync_bypass_in ? empty_raw : empty_sync;

  ////////////////////////////////////////////////////////////////////////
  // Read side

  // The flag lags the pointers by two cycles after the last word is read,
  // so the raw compare also refuses a read at the write pointer
  assign rd_room = !empty_raw;

  // Reading stops at the flagged or raw empty, so unwritten entries are never read
  assign rd_go = link.rd_en && !empty_now && rd_room;

  always_comb begin
    if (rd_go) begin
      rd_ptr_d = rd_ptr_q + rxfifo_pkg::RXFIFO_PTR_ONE;
    end else begin
      rd_ptr_d = rd_ptr_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_ptr_q <= rxfifo_pkg::RXFIFO_PTR_RST;
    end else begin
      rd_ptr_q <= rd_ptr_d;
    end
  end

  // Output follows the entry under the read pointer every cycle
  // With reads locked, wrapping writes refresh the shown entry
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q_q <= rxfifo_pkg::RXFIFO_DATA_RST;
    end else begin
      q_q <= mem_q[rd_ptr_q];
    end
  end

  // Serial echo only in narrow mode
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      echo_q <= 1'b0;
    end else if (width8_sel_in) begin
      echo_q <= 1'b0;
    end else begin
      echo_q <= serial_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status

  // Write landing while seven words are held catches up with the read pointer
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      overrun_q <= 1'b0;
    end else if (wr_strobe_in && !rd_go && (wr_ptr_d == rd_ptr_q)) begin
      overrun_q <= 1'b1;
    end else begin
      overrun_q <= 1'b0;
    end
  end

  // Words written and not yet read, modulo eight
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      level_q <= rxfifo_pkg::RXFIFO_PTR_RST;
    end else begin
      level_q <= wr_ptr_d - rd_ptr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign link.empty = empty_now;
  assign link.q = q_q;
  assign link.serial_echo = echo_q;
  assign link.fill_clk_copy = fill_clk_q;
  assign overrun_out = overrun_q;
  assign level_out = level_q;

endmodule : rxfifo_dev

/* src/rxfifo_pkg.sv */
// Constants shared by the receive crossing FIFO and its user-side reader.
// Assumes a single system clock and synchronous active-high reset.
package rxfifo_pkg;

  localparam int unsigned RXFIFO_DATA_W = 8;
  localparam int unsigned RXFIFO_NARROW_W = 4;
  localparam int unsigned RXFIFO_DEPTH = 8;
  localparam int unsigned RXFIFO_PTR_W = 3;
  localparam int unsigned RXFIFO_SYNC_STAGES = 2;
  localparam int unsigned RXFIFO_ALIGN_PIPE = 2;

  localparam logic [RXFIFO_PTR_W-1:0] RXFIFO_PTR_RST = 3'h0;
  localparam logic [RXFIFO_DATA_W-1:0] RXFIFO_DATA_RST = 8'h00;
  localparam logic [RXFIFO_DATA_W-1:0] RXFIFO_NARROW_MASK = 8'h0f;
  localparam logic RXFIFO_EMPTY_RST = 1'b1;
  localparam logic [RXFIFO_PTR_W-1:0] RXFIFO_PTR_ONE = 3'h1;

  typedef logic [RXFIFO_DATA_W-1:0] rxfifo_word_t;
  typedef logic [RXFIFO_PTR_W-1:0] rxfifo_ptr_t;

  typedef enum logic {
    RXFIFO_ALIGN_SINGLE,
    RXFIFO_ALIGN_MULTI
  } rxfifo_align_t;

endpackage : rxfifo_pkg

/* src/rxfifo_link_if.sv */
// Link between the slice FIFO and the user logic that reads it.
// Assumes both ends share clk_in; the testbench connects the two modports.
`timescale 1ns/100ps
interface rxfifo_link_if;
  logic rd_en;
  logic empty;
  rxfifo_pkg::rxfifo_word_t q;
  logic serial_echo;
  logic fill_clk_copy;

  modport dev (
    input rd_en,
    output empty,
    output q,
    output serial_echo,
    output fill_clk_copy
  );

  modport usr (
    output rd_en,
    input empty,
    input q,
    input serial_echo,
    input fill_clk_copy
  );
endinterface : rxfifo_link_if

/* src/rxfifo_sync.sv */
// Two-stage level synchroniser for the empty condition.
// Assumes the input is a level that may change at any cycle.
`timescale 1ns/100ps
module rxfifo_sync (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic level_in,
  output logic level_out
);

  logic meta_q;
  logic hold_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q <= rxfifo_pkg::RXFIFO_EMPTY_RST;
      hold_q <= rxfifo_pkg::RXFIFO_EMPTY_RST;
    end else begin
      meta_q <= level_in;
      hold_q <= meta_q;
    end
  end

  assign level_out = hold_q;

endmodule : rxfifo_sync

/* src/rxfifo_usr.sv */
// User-side reader: aligns read enables across slices and takes words.
// Assumes peer slice empty flags arrive on clk_in from sibling FIFOs.
`timescale 1ns/100ps
module rxfifo_usr (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic tracking_ready_in,
  input wire rxfifo_pkg::rxfifo_align_t align_mode_in,
  input wire logic far_empty_in,
  input wire logic [2:0] peer_empty_in,
  input wire logic slip_in,
  output logic rd_en_out,
  output rxfifo_pkg::rxfifo_word_t data_out,
  output logic data_valid_out,
  rxfifo_link_if.usr link
);

  ////////////////////////////////////////////////////////////////////////
  // Read enable alignment

  logic start_raw;
  logic [rxfifo_pkg::RXFIFO_ALIGN_PIPE-1:0] pipe_q;
  logic taken_q;
  logic [2:0] slip_q;
  rxfifo_pkg::rxfifo_word_t data_q;

  always_comb begin
    unique case (align_mode_in)
      rxfifo_pkg::RXFIFO_ALIGN_SINGLE: start_raw = ~far_empty_in;
      rxfifo_pkg::RXFIFO_ALIGN_MULTI: start_raw = ~(|{peer_empty_in, link.empty});
    endcase
  end

  // Held low until the slice reports tracking ready
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pipe_q <= '0;
    end else begin
      pipe_q <= {pipe_q[rxfifo_pkg::RXFIFO_ALIGN_PIPE-2:0],
                 start_raw & tracking_ready_in};
    end
  end

  assign link.rd_en = pipe_q[rxfifo_pkg::RXFIFO_ALIGN_PIPE-1];
  assign rd_en_out = link.rd_en;

  ////////////////////////////////////////////////////////////////////////
  // Word capture and bit slip

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      slip_q <= 3'h0;
    end else if (slip_in) begin
      slip_q <= slip_q + 3'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      taken_q <= 1'b0;
    end else begin
      taken_q <= link.rd_en && !link.empty && tracking_ready_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      data_q <= rxfifo_pkg::RXFIFO_DATA_RST;
    end else if (taken_q) begin
      data_q <= rxfifo_pkg::rxfifo_word_t'({link.q, link.q} >> slip_q);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      data_valid_out <= 1'b0;
    end else begin
      data_valid_out <= taken_q;
    end
  end

  assign data_out = data_q;

endmodule : rxfifo_usr

/* verif/rxfifo_props.sv */
// Checker on the FIFO link signals and the inputs that cause them.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module rxfifo_props (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic rd_en,
  input wire logic empty,
  input wire rxfifo_pkg::rxfifo_word_t q,
  input wire logic serial_echo,
  input wire logic fill_clk_copy,
  input wire logic wr_strobe_in,
  input wire logic serial_in,
  input wire logic width8_sel_in,
  input wire logic sync_bypass_in,
  input wire logic tracking_ready_in,
  input wire rxfifo_pkg::rxfifo_align_t align_mode_in,
  input wire logic far_empty_in,
  input wire logic [2:0] peer_empty_in
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  logic start;
  assign start = tracking_ready_in && ((align_mode_in == rxfifo_pkg::RXFIFO_ALIGN_SINGLE) ?
    !far_empty_in : !(|{peer_empty_in, empty}));
  ////////////////////////////////////////////////////////////////////////////////
  a_rst_state: assert property ($fell(rst_in) |-> empty && q == 8'h00 && !rd_en)
    else $error("state after reset wrong");
  a_fill_toggle: assert property ($past(!rst_in) |->
    fill_clk_copy == ($past(fill_clk_copy) ^ $past(wr_strobe_in)))
    else $error("fill clock copy does not follow writes");
  a_echo_copy: assert property (!width8_sel_in |=> serial_echo == $past(serial_in))
    else $error("serial echo wrong");
  a_narrow_upper: assert property (!width8_sel_in && !empty |-> q[7:4] == 4'h0)
    else $error("upper nibble not zero");
  a_empty_sync_lag: assert property (
    (empty && !wr_strobe_in && !sync_bypass_in) [*3] ##1
    (wr_strobe_in && !sync_bypass_in) |-> empty [*3] ##1 !empty)
    else $error("empty fall timing wrong");
  a_bypass_empty: assert property (sync_bypass_in && wr_strobe_in |=> !empty)
    else $error("raw empty stays high after write");
  a_align_pipe: assert property (
    $past(!rst_in, 2) && $past(!rst_in) |-> rd_en == $past(start, 2))
    else $error("read enable alignment wrong");
  a_q_locked: assert property (
    (!rd_en && !wr_strobe_in && !empty) [*2] |=> $stable(q))
    else $error("output moved while locked");
  c_empty_fall: cover property ($fell(empty));
  c_rd_start: cover property ($rose(rd_en));
  c_echo_rise: cover property ($rose(serial_echo));
endmodule : rxfifo_props

/* verif/test_rxfifo.sv */
// Testbench joining both FIFO ends through the link interface.
// Assumes the design package and interface are compiled first.
`timescale 1ns/100ps
module test_rxfifo;
  logic clk_in, rst_in, width8_sel, bypass, serial, wr_strobe, ready, far_empty, slip;
  logic overrun, rd_en_o, data_valid;
  logic [2:0] peer_empty;
  rxfifo_pkg::rxfifo_word_t wr_data, data_o;
  rxfifo_pkg::rxfifo_ptr_t level;
  rxfifo_pkg::rxfifo_align_t mode;
  int err_total, checks_done;
  rxfifo_link_if link ();
  rxfifo_dev i_rxfifo_dev (.clk_in(clk_in), .rst_in(rst_in), .width8_sel_in(width8_sel),
    .sync_bypass_in(bypass), .serial_in(serial), .wr_strobe_in(wr_strobe),
    .wr_data_in(wr_data), .overrun_out(overrun), .level_out(level), .link(link.dev));
  rxfifo_usr i_rxfifo_usr (.clk_in(clk_in), .rst_in(rst_in), .tracking_ready_in(ready),
    .align_mode_in(mode), .far_empty_in(far_empty), .peer_empty_in(peer_empty),
    .slip_in(slip), .rd_en_out(rd_en_o), .data_out(data_o), .data_valid_out(data_valid),
    .link(link.usr));
  rxfifo_props i_rxfifo_props (.clk_in(clk_in), .rst_in(rst_in), .rd_en(link.rd_en),
    .empty(link.empty), .q(link.q), .serial_echo(link.serial_echo),
    .fill_clk_copy(link.fill_clk_copy), .wr_strobe_in(wr_strobe), .serial_in(serial),
    .width8_sel_in(width8_sel), .sync_bypass_in(bypass), .tracking_ready_in(ready),
    .align_mode_in(mode), .far_empty_in(far_empty), .peer_empty_in(peer_empty));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({7'h00, got}, {7'h00, exp});
  endtask : chk_bit
  task automatic restart(input logic w8, input logic byp);
    @(posedge clk_in);
    rst_in <= 1'b1;
    width8_sel <= w8;
    bypass <= byp;
    ready <= 1'b0;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask : restart
  task automatic wr(input logic [7:0] d);
    @(posedge clk_in);
    wr_strobe <= 1'b1;
    wr_data <= d;
    @(posedge clk_in);
    wr_strobe <= 1'b0;
  endtask : wr
  task automatic get(output logic [7:0] w);
    int n;
    n = 0;
    while (data_valid !== 1'b1 && n < 40) begin
      @(negedge clk_in);
      n++;
    end
    if (data_valid !== 1'b1) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, 8'h00, 8'h01);
    end
    w = data_o;
    @(negedge clk_in);
  endtask : get
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  initial begin
    #(50 * 4000);
    err_total++;
    tally_and_finish();
  end
  initial begin
    logic [7:0] w;
    {width8_sel, bypass, serial, wr_strobe, ready, far_empty, slip} = 7'h00;
    rst_in = 1'b1;
    wr_data = 8'h00;
    peer_empty = 3'h0;
    mode = rxfifo_pkg::RXFIFO_ALIGN_MULTI;
    err_total = 0;
    checks_done = 0;
    // Narrow mode, no reads
    restart(1'b0, 1'b0);
    @(negedge clk_in);
    chk_bit(link.empty, 1'b1);
    wr(8'ha5);
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    chk_bit(link.empty, 1'b0);
    chk_word(link.q, 8'h05);
    @(posedge clk_in);
    serial <= 1'b1;
    @(posedge clk_in);
    @(negedge clk_in);
    chk_bit(link.serial_echo, 1'b1);
    for (int i = 1; i <= 8; i++) begin
      wr(i[7:0]);
      if (i == 7) begin
        @(negedge clk_in);
        chk_bit(overrun, 1'b1);
      end
    end
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    chk_word(link.q, 8'h08);
    chk_word({5'h00, level}, 8'h01);
    chk_bit(data_valid, 1'b0);
    chk_bit(overrun, 1'b0);
    $display("test narrow done");
    // Wide mode, read held off by a peer
    restart(1'b1, 1'b0);
    peer_empty <= 3'h4;
    ready <= 1'b1;
    wr(8'h3c);
    wr(8'hc3);
    wr(8'h5a);
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
    chk_bit(data_valid, 1'b0);
    chk_bit(rd_en_o, 1'b0);
    chk_bit(link.serial_echo, 1'b0);
    @(posedge clk_in);
    peer_empty <= 3'h0;
    get(w);
    chk_word(w, 8'h3c);
    get(w);
    chk_word(w, 8'hc3);
    get(w);
    chk_word(w, 8'h5a);
    $display("test wide done");
    // Bypass, single alignment, one slip
    restart(1'b1, 1'b1);
    mode <= rxfifo_pkg::RXFIFO_ALIGN_SINGLE;
    far_empty <= 1'b1;
    ready <= 1'b1;
    slip <= 1'b1;
    @(posedge clk_in);
    slip <= 1'b0;
    wr(8'h81);
    @(negedge clk_in);
    chk_bit(link.empty, 1'b0);
    @(posedge clk_in);
    far_empty <= 1'b0;
    get(w);
    chk_word(w, 8'hc0);
    chk_bit(rd_en_o, 1'b1);
    $display("test bypass done");
    tally_and_finish();
  end
endmodule : test_rxfifo
